// ==== common/branch_pkg.sv ====
// Shared constants and types for the conditional branch unit.
package branch_pkg;
	// ==========================================================
	// Widths
	localparam int PC_WIDTH = 16;
	localparam int OFFSET_WIDTH = 7;

	// ==========================================================
	// Reset values and cycle counts
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam int TAKEN_CYCLES = 2;
	localparam int NOT_TAKEN_CYCLES = 1;

	// ==========================================================
	// Branch condition codes supplied by the decoder
	typedef enum logic [2:0] {
		branch_if_lower,
		branch_if_same_or_higher,
		branch_if_negative,
		branch_if_positive,
		branch_if_signed_ge,
		branch_if_signed_lt,
		branch_if_halfcarry_set,
		branch_if_halfcarry_clear
	} branch_op_type;
endpackage

// ==== hdl/branch_condition.sv ====
// Combinational evaluation of a branch condition against the status flags.
`timescale 1ns/1ps
module branch_condition (
	input wire branch_pkg::branch_op_type op, // Decoded branch kind.
	input wire logic flag_c, // Carry flag.
	input wire logic flag_n, // Negative flag.
	input wire logic flag_v, // Overflow flag.
	input wire logic flag_h, // Half-carry flag.
	output logic cond_true // High when the branch is taken.
);
	// ==========================================================
	// Condition table
	// Signed compares use N xor V so overflowed subtractions still order correctly.
	always_comb begin
		unique case (op)
			branch_pkg::branch_if_lower: cond_true = flag_c;
			branch_pkg::branch_if_same_or_higher: cond_true = !flag_c;
			branch_pkg::branch_if_negative: cond_true = flag_n;
			branch_pkg::branch_if_positive: cond_true = !flag_n;
			branch_pkg::branch_if_signed_ge: cond_true = !(flag_n ^ flag_v);
			branch_pkg::branch_if_signed_lt: cond_true = flag_n ^ flag_v;
			branch_pkg::branch_if_halfcarry_set: cond_true = flag_h;
			branch_pkg::branch_if_halfcarry_clear: cond_true = !flag_h;
		endcase
	end
endmodule

// ==== hdl/branch_unit.sv ====
// Conditional relative branch unit: condition test, target and cycle timing.
// How it works
// - Lower: jump when carry is set.
// - Negative: jump when N is set.
// - Positive: jump when N is clear.
// - Signed ge: jump when N xor V clear.
// - Signed lt: jump when N xor V set.
// - Half-carry set: jump when H set.
// - Half-carry clear: jump when H clear; flags untouched, 1/2 cycles.
`timescale 1ns/1ps
module branch_unit (
	input wire logic clk_sys, // Core clock, 125 MHz.
	input wire logic reset, // Synchronous, active high.
	input wire logic issue_valid, // Decoder presents a branch this cycle.
	output logic issue_ready, // Unit can accept a branch.
	input wire branch_pkg::branch_op_type issue_op, // Branch kind.
	input wire logic [6:0] issue_offset, // Signed offset k.
	input wire logic [15:0] pc_current, // Address of the branch instruction.
	input wire logic flag_c, // Carry flag.
	input wire logic flag_n, // Negative flag.
	input wire logic flag_v, // Overflow flag.
	input wire logic flag_h, // Half-carry flag.
	output logic [15:0] pc_next, // Next program counter, registered.
	output logic pc_load, // One-cycle pulse: pc_next is a jump target.
	output logic done, // One-cycle pulse: branch completed.
	output logic flags_write // Always low: branches never alter flags.
);
	typedef enum {idle_st, taken_st} state_type;
	state_type state_reg;
	logic cond_true;
	logic [15:0] target_next;

	// ==========================================================
	// Condition evaluation
	// The condition table is pure logic on the live flags. The flags must therefore be
	// settled in the issue cycle, because the unit keeps no copy of them.
	branch_condition branch_condition_inst (
		.op(issue_op),
		.flag_c(flag_c),
		.flag_n(flag_n),
		.flag_v(flag_v),
		.flag_h(flag_h),
		.cond_true(cond_true)
	);

	// Sign-extend k and add PC plus one, wrapping in the 16-bit space.
	function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [6:0] k);
		logic [15:0] ext;
		ext = {{9{k[6]}}, k};
		return 16'(pc + ext + 16'h0001);
	endfunction

	// Target, handshake and flag strobe.
	// Ready is combinational so that a not-taken branch can follow at the very next edge.
	// It drops only for the one busy cycle after a taken branch is accepted, before its target loads.
	assign target_next = rel_target(pc_current, issue_offset);
	assign issue_ready = (state_reg == idle_st);
	assign flags_write = 1'b0;

	// ==========================================================
	// Sequencing: a taken branch spends a second cycle while the target loads.
	// A second state is all that the taken path needs, so no counter is kept.
	// The trade-off is that the two-cycle figure is fixed by the structure itself.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= idle_st;
		end else begin
			unique case (state_reg)
				idle_st: begin
					if (issue_valid && cond_true) begin
						state_reg <= taken_st;
					end
				end
				taken_st: state_reg <= idle_st;
			endcase
		end
	end

	// Results; the fall-through address is PC plus one.
	// pc_next is written at the accept edge and then held until the next accepted branch.
	// The done and pc_load pulses last one cycle only, so callers must not poll them late.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pc_next <= branch_pkg::PC_RESET;
			pc_load <= 1'b0;
			done <= 1'b0;
		end else begin
			pc_load <= 1'b0;
			done <= 1'b0;
			if (state_reg == idle_st && issue_valid) begin
				if (cond_true) begin
					pc_next <= target_next;
				end else begin
					pc_next <= 16'(pc_current + 16'h0001);
					done <= 1'b1;
				end
			end else if (state_reg == taken_st) begin
				pc_load <= 1'b1;
				done <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Checks
	// Target captured at the accept edge, for comparison when the load pulse comes.
	logic [15:0] exp_reg;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			exp_reg <= 16'h0000;
		end else if (issue_valid && issue_ready) begin
			exp_reg <= 16'(pc_current + {{9{issue_offset[6]}}, issue_offset} + 16'h0001);
		end
	end

	sequence taken_issue;
		issue_valid && issue_ready && cond_true;
	endsequence

	sequence fail_issue;
		issue_valid && issue_ready && !cond_true;
	endsequence

	chk_lower_carry: assert property (@(posedge clk_sys) disable iff (reset)
		issue_valid && issue_ready && issue_op == branch_pkg::branch_if_lower && flag_c
		|-> ##2 pc_load) else $error("lower branch not taken with carry set");
	chk_negative_taken: assert property (@(posedge clk_sys) disable iff (reset)
		issue_valid && issue_ready && issue_op == branch_pkg::branch_if_negative
		|-> ##1 (state_reg == taken_st) == $past(flag_n)) else $error("negative branch wrong");
	chk_positive_taken: assert property (@(posedge clk_sys) disable iff (reset)
		issue_valid && issue_ready && issue_op == branch_pkg::branch_if_positive
		|-> ##1 (state_reg == taken_st) != $past(flag_n)) else $error("positive branch wrong");
	chk_signed_ge: assert property (@(posedge clk_sys) disable iff (reset)
		issue_valid && issue_ready && issue_op == branch_pkg::branch_if_signed_ge
		&& (flag_n ^ flag_v) |-> ##1 done && !pc_load) else $error("signed ge taken wrongly");
	chk_signed_lt: assert property (@(posedge clk_sys) disable iff (reset)
		issue_valid && issue_ready && issue_op == branch_pkg::branch_if_signed_lt
		&& !(flag_n ^ flag_v) |-> ##1 done && !pc_load) else $error("signed lt taken wrongly");
	chk_halfcarry_set: assert property (@(posedge clk_sys) disable iff (reset)
		issue_valid && issue_ready && issue_op == branch_pkg::branch_if_halfcarry_set && !flag_h
		|-> ##1 done ##1 !pc_load) else $error("half-carry set branch taken wrongly");
	chk_target_value: assert property (@(posedge clk_sys) disable iff (reset)
		taken_issue |-> ##1 !done ##1 pc_load && done && pc_next == exp_reg)
		else $error("taken branch target or timing wrong");
	chk_fall_through: assert property (@(posedge clk_sys) disable iff (reset)
		fail_issue |-> ##1 done && !pc_load && pc_next == $past(pc_current) + 16'h0001)
		else $error("fall-through wrong");
	chk_flags_kept: assert property (@(posedge clk_sys) disable iff (reset)
		!flags_write) else $error("branch wrote flags");

	// ==========================================================
	// Step sequences of a branch after its accept edge
	// The busy cycle of a taken branch: no pulse yet and new branches refused.
	sequence busy_cycle;
		!issue_ready && !done && !pc_load;
	endsequence

	// The closing cycle of a taken branch: target valid and ready again.
	sequence taken_finish;
		pc_load && done && issue_ready;
	endsequence

	// The single cycle of a branch whose condition fails.
	sequence fall_finish;
		done && !pc_load;
	endsequence

	// Lower with carry clear falls through.
	chk_lower_clear: assert property (@(posedge clk_sys) disable iff (reset)
		issue_valid && issue_ready && issue_op == branch_pkg::branch_if_lower && !flag_c
		|-> ##1 fall_finish) else $error("lower branch taken with carry clear");

	// Negative with N set runs the full two-cycle taken path.
	chk_negative_target: assert property (@(posedge clk_sys) disable iff (reset)
		issue_valid && issue_ready && issue_op == branch_pkg::branch_if_negative && flag_n
		|-> ##1 busy_cycle ##1 taken_finish) else $error("negative branch timing wrong");

	// Positive with N clear runs the full two-cycle taken path.
	chk_positive_target: assert property (@(posedge clk_sys) disable iff (reset)
		issue_valid && issue_ready && issue_op == branch_pkg::branch_if_positive && !flag_n
		|-> ##1 busy_cycle ##1 taken_finish) else $error("positive branch timing wrong");

	// Signed greater-or-equal is taken when N and V agree.
	chk_ge_taken: assert property (@(posedge clk_sys) disable iff (reset)
		issue_valid && issue_ready && issue_op == branch_pkg::branch_if_signed_ge
		&& !(flag_n ^ flag_v) |-> ##1 busy_cycle ##1 taken_finish)
		else $error("signed ge not taken");

	// Signed less-than is taken when N and V differ.
	chk_lt_taken: assert property (@(posedge clk_sys) disable iff (reset)
		issue_valid && issue_ready && issue_op == branch_pkg::branch_if_signed_lt
		&& (flag_n ^ flag_v) |-> ##1 busy_cycle ##1 taken_finish)
		else $error("signed lt not taken");

	// Half-carry set is taken when H is set.
	chk_halfcarry_taken: assert property (@(posedge clk_sys) disable iff (reset)
		issue_valid && issue_ready && issue_op == branch_pkg::branch_if_halfcarry_set
		&& flag_h |-> ##1 busy_cycle ##1 taken_finish)
		else $error("half-carry set branch not taken");

	// Half-carry clear is taken when H is clear.
	chk_halfclear_taken: assert property (@(posedge clk_sys) disable iff (reset)
		issue_valid && issue_ready && issue_op == branch_pkg::branch_if_halfcarry_clear
		&& !flag_h |-> ##1 busy_cycle ##1 taken_finish)
		else $error("half-carry clear branch not taken");

	// Half-carry clear falls through when H is set.
	chk_halfclear_kept: assert property (@(posedge clk_sys) disable iff (reset)
		issue_valid && issue_ready && issue_op == branch_pkg::branch_if_halfcarry_clear
		&& flag_h |-> ##1 fall_finish) else $error("half-carry clear branch taken wrongly");

	// Without an accepted branch the result register must not move, refused offers included.
	chk_pc_next_held: assert property (@(posedge clk_sys) disable iff (reset)
		!(issue_valid && issue_ready) |=> $stable(pc_next))
		else $error("pc_next changed without an accepted branch");

	// The busy cycle lasts exactly one cycle.
	chk_busy_one_cycle: assert property (@(posedge clk_sys) disable iff (reset)
		!issue_ready |=> issue_ready) else $error("busy state lasted too long");

	// A target load always completes the branch in the same cycle.
	chk_load_with_done: assert property (@(posedge clk_sys) disable iff (reset)
		pc_load |-> done) else $error("target load without done");

	// Reset cancels any branch in flight and restores the idle outputs.
	chk_reset_quiet: assert property (@(posedge clk_sys)
		reset |=> !pc_load && !done && issue_ready && pc_next == branch_pkg::PC_RESET)
		else $error("outputs not idle after reset");
endmodule

// ==== bench/status_flag_model.sv ====
// Partner model: the status register that feeds flags to the branch unit.
`timescale 1ns/1ps
module status_flag_model (
	input wire logic clk_sys, // Core clock.
	input wire logic load, // Load new flag values.
	input wire logic [3:0] flags_in, // Order: carry, negative, overflow, half-carry.
	output logic [3:0] flags_reg // Flags held for the unit.
);
	// ==========================================================
	// Flags change only on a load, as the real register would.
	always_ff @(posedge clk_sys) begin
		if (load) begin
			flags_reg <= flags_in;
		end
	end
endmodule

// ==== bench/conditional_branch_unit_tb_top.sv ====
// Self-checking bench for the branch unit with random and corner branches.
`timescale 1ns/1ps
module conditional_branch_unit_tb_top;
	logic clk_sys = 0, reset = 1, issue_valid = 0, load = 0, issue_ready, pc_load, done, flags_write;
	logic [3:0] flags_in = 0, f;
	logic [6:0] issue_offset = 0;
	logic [15:0] pc_current = 0, pc_next;
	logic [31:0] seed = 32'h8ccf_0d8a;
	branch_pkg::branch_op_type issue_op = branch_pkg::branch_if_lower;
	int failures = 0, check_count = 0, cycles = 0;
	always #4 clk_sys = ~clk_sys;
	status_flag_model status_flag_model_inst (.clk_sys(clk_sys), .load(load),
		.flags_in(flags_in), .flags_reg(f));
	branch_unit branch_unit_inst (.clk_sys(clk_sys), .reset(reset), .issue_valid(issue_valid),
		.issue_ready(issue_ready), .issue_op(issue_op), .issue_offset(issue_offset),
		.pc_current(pc_current), .flag_c(f[3]), .flag_n(f[2]), .flag_v(f[1]), .flag_h(f[0]),
		.pc_next(pc_next), .pc_load(pc_load), .done(done), .flags_write(flags_write));
	// ==========================================================
	// Reference condition, worked out from the flag equations.
	function automatic logic take(int o, logic [3:0] x);
		case (o)
			0: return x[3];
			1: return !x[3];
			2: return x[2];
			3: return !x[2];
			4: return !(x[2] ^ x[1]);
			5: return x[2] ^ x[1];
			6: return x[0];
			default: return !x[0];
		endcase
	endfunction
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(logic ok, string m);
		check_count++;
		if (ok !== 1'b1) begin
			failures++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	// ==========================================================
	// One branch: load flags, offer it once, then watch its 1 or 2 cycles.
	task automatic run(int o, logic [6:0] k, logic [15:0] pc, logic [3:0] x);
		logic t;
		logic [15:0] tgt;
		t = take(o, x);
		tgt = pc + {{9{k[6]}}, k} + 16'h0001;
		@(negedge clk_sys);
		flags_in = x;
		load = 1;
		@(negedge clk_sys);
		load = 0;
		issue_valid = 1;
		issue_op = branch_pkg::branch_op_type'(o);
		issue_offset = k;
		pc_current = pc;
		@(negedge clk_sys);
		if (t) begin
			chk(issue_ready === 1'b0 && done === 1'b0, "taken first cycle");
			// Keep offering a moved branch in the busy cycle; it must be refused.
			pc_current = ~pc;
			@(negedge clk_sys);
			issue_valid = 0;
			chk(done === 1'b1 && pc_load === 1'b1 && pc_next === tgt, "taken target");
		end else begin
			issue_valid = 0;
			chk(done === 1'b1 && pc_load === 1'b0 && pc_next === pc + 16'h0001, "fall");
		end
		chk(flags_write === 1'b0, "flags touched");
	endtask
	task automatic complete_run();
		$display("failures %0d checks %0d", failures, check_count);
		if (failures == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Hang guard: far above the fewer than 1,400 cycles the sequence needs.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			complete_run();
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 0;
		chk(pc_next === branch_pkg::PC_RESET && issue_ready === 1'b1, "reset values");
		chk(pc_load === 1'b0 && done === 1'b0, "reset pulses");
		for (int o = 0; o < 8; o++) begin
			run(o, 7'h40, 16'h0000, 4'h0);
			run(o, 7'h3f, 16'hffff, 4'hf);
			run(o, 7'h7f, 16'h1234, 4'h4);
		end
		// Reset in the busy cycle of a taken branch must cancel its completion.
		@(negedge clk_sys);
		flags_in = 4'h8;
		load = 1;
		@(negedge clk_sys);
		load = 0;
		issue_valid = 1;
		issue_op = branch_pkg::branch_if_lower;
		issue_offset = 7'h05;
		pc_current = 16'h0100;
		@(negedge clk_sys);
		issue_valid = 0;
		reset = 1;
		@(negedge clk_sys);
		reset = 0;
		chk(pc_next === branch_pkg::PC_RESET && issue_ready === 1'b1, "mid-run reset");
		chk(pc_load === 1'b0 && done === 1'b0, "mid-run pulses");
		repeat (300) begin
			seed = lfsr(seed);
			run(seed[2:0], seed[9:3], seed[25:10], seed[29:26]);
		end
		complete_run();
	end
endmodule
